// ===== dmarm_ring_mgr.v
`timescale 1ns/1ps
`include "dmarm_defs.vh"
module dmarm_ring_mgr #(
	parameter SEC_CYCLES = `DMARM_SEC_NS / `DMARM_CLK_NS
) (
	// clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output reg  [31:0] prdata,
	output reg         pslverr,
	// descriptor fetch request and response
	output reg         desc_req_valid,
	output reg  [31:0] desc_req_addr,
	output reg  [1:0]  desc_req_chan,
	input  wire        desc_rsp_valid,
	input  wire [31:0] desc_rsp_buf,
	input  wire [19:0] desc_rsp_len,
	input  wire        desc_rsp_sop,
	input  wire        desc_rsp_eop,
	input  wire        desc_rsp_irq,
	input  wire [31:0] desc_rsp_user,
	input  wire        desc_rsp_err,
	// data movement request and result
	output reg         xfer_valid,
	output reg  [1:0]  xfer_chan,
	output reg         xfer_c2h,
	output reg  [31:0] xfer_buf,
	output reg  [19:0] xfer_len,
	output reg         xfer_sop,
	output reg         xfer_eop,
	output reg  [31:0] xfer_user,
	input  wire        xfer_done,
	input  wire [19:0] xfer_count,
	input  wire        xfer_err,
	input  wire        xfer_short,
	input  wire        xfer_rx_sop,
	input  wire        xfer_rx_eop,
	input  wire [31:0] xfer_ustat,
	// descriptor write-back
	output reg         wb_valid,
	output reg  [31:0] wb_addr,
	output reg  [31:0] wb_status,
	output reg  [31:0] wb_ustat,
	// software notification
	output reg  [3:0]  pkt_done_pulse,
	output reg  [3:0]  coal_pulse
);
	localparam [3:0] S_IDLE  = 4'b0001;
	localparam [3:0] S_FETCH = 4'b0010;
	localparam [3:0] S_MOVE  = 4'b0100;
	localparam [3:0] S_WB    = 4'b1000;

	integer i;
	integer j;

	////////////////////////////////////////////////////////////////////////////////
	// per-channel state, then shared engine state
	reg [31:0] ctrl_q  [0:3];
	reg [31:0] base_q  [0:3];
	reg [31:0] fetch_q [0:3];
	reg [31:0] tail_q  [0:3];
	reg [31:0] done_q  [0:3];
	reg [15:0] coal_q  [0:3];
	reg [3:0]  state_q;
	reg [1:0]  cur_q;
	reg [1:0]  rr_q;
	reg        d_irq_q;
	reg        d_err_q;
	reg [31:0] sec_q;
	reg        sec_tick_q;

	wire [31:0] act_ns [0:3];
	wire [31:0] wait_ns [0:3];
	wire [15:0] err_cnt [0:3];
	wire [15:0] short_cnt [0:3];

	////////////////////////////////////////////////////////////////////////////////
	// apb decode
	wire       setup    = psel & ~penable;
	wire       access   = psel & penable;
	wire       in_chan  = (paddr[11:7] == 5'h00) & (paddr[1:0] == 2'b00);
	wire       is_id    = (paddr == `DMARM_OFF_ID);
	wire [1:0] a_ch     = paddr[6:5];
	wire [2:0] a_reg    = paddr[4:2];
	wire       wr_ok    = access & pwrite & in_chan;

	// zero wait states: every register answers in its first access cycle
	assign pready = 1'b1;

	reg [31:0] rd_mux;
	always @* begin
		rd_mux = 32'h0000_0000;
		if (is_id) begin
			rd_mux = `DMARM_ID_VALUE;  // arbitrary identification value
		end else if (in_chan) begin
			case (a_reg)
				`DMARM_REG_CTRL:   rd_mux = ctrl_q[a_ch];
				`DMARM_REG_BASE:   rd_mux = base_q[a_ch];
				`DMARM_REG_FETCH:  rd_mux = fetch_q[a_ch];
				`DMARM_REG_TAIL:   rd_mux = tail_q[a_ch];
				`DMARM_REG_DONE:   rd_mux = done_q[a_ch];
				`DMARM_REG_ACTIVE: rd_mux = act_ns[a_ch];  // see RULE19
				`DMARM_REG_WAIT:   rd_mux = wait_ns[a_ch];  // see RULE20
				`DMARM_REG_ERRS:   rd_mux = {short_cnt[a_ch], err_cnt[a_ch]};
				default:           rd_mux = 32'h0000_0000;
			endcase
		end
	end

	// read data captured in setup so it comes from a flop in access
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata  <= rd_mux;
			pslverr <= ~(in_chan | (is_id & ~pwrite));
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// channel selection: any enabled channel whose fetch differs from tail
	reg [3:0] ready_ch;
	reg [1:0] pick;
	reg       pick_ok;
	reg [1:0] cand;
	always @* begin
		pick    = 2'b00;
		pick_ok = 1'b0;
		cand    = 2'b00;
		for (i = 0; i < `DMARM_NCHAN; i = i + 1) begin
			// see RULE23 see RULE5 see RULE7
			ready_ch[i] = ctrl_q[i][`DMARM_CTRL_EN] & (fetch_q[i] != tail_q[i]);
		end
		// round robin from the channel after the last one served, see RULE2
		for (i = 4; i > 0; i = i - 1) begin
			cand = rr_q + i[1:0];
			if (ready_ch[cand]) begin
				pick    = cand;
				pick_ok = 1'b1;
			end
		end
	end

	wire        cur_c2h  = ctrl_q[cur_q][`DMARM_CTRL_C2H];
	wire [31:0] cur_ptr  = fetch_q[cur_q];
	// see RULE22
	wire [31:0] next_ptr = (cur_ptr == base_q[cur_q] + `DMARM_RING_LAST) ?
	                       base_q[cur_q] : cur_ptr + `DMARM_DESC_BYTES;
	wire        wb_sop   = cur_c2h ? xfer_rx_sop : xfer_sop;
	wire        wb_eop   = cur_c2h ? xfer_rx_eop : xfer_eop;
	wire        finish   = (state_q == S_WB);
	wire [15:0] coal_n   = ctrl_q[cur_q][`DMARM_CTRL_N_HI:`DMARM_CTRL_N_LO];

	////////////////////////////////////////////////////////////////////////////////
	// descriptor engine
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q        <= S_IDLE;
			cur_q          <= 2'b00;
			rr_q           <= 2'b00;
			d_irq_q        <= 1'b0;
			d_err_q        <= 1'b0;
			desc_req_valid <= 1'b0;
			desc_req_addr  <= 32'h0000_0000;
			desc_req_chan  <= 2'b00;
			xfer_valid     <= 1'b0;
			xfer_chan      <= 2'b00;
			xfer_c2h       <= 1'b0;
			xfer_buf       <= 32'h0000_0000;
			xfer_len       <= 20'h00000;
			xfer_sop       <= 1'b0;
			xfer_eop       <= 1'b0;
			xfer_user      <= 32'h0000_0000;
			wb_valid       <= 1'b0;
			wb_addr        <= 32'h0000_0000;
			wb_status      <= 32'h0000_0000;
			wb_ustat       <= 32'h0000_0000;
			pkt_done_pulse <= 4'h0;
		end else begin
			wb_valid       <= 1'b0;
			pkt_done_pulse <= 4'h0;
			case (state_q)
				S_IDLE: begin
					if (pick_ok) begin
						cur_q          <= pick;
						desc_req_valid <= 1'b1;
						desc_req_addr  <= fetch_q[pick];
						desc_req_chan  <= pick;
						state_q        <= S_FETCH;
					end
				end
				S_FETCH: begin
					if (desc_rsp_valid) begin
						desc_req_valid <= 1'b0;
						d_irq_q        <= desc_rsp_irq;
						d_err_q        <= desc_rsp_err;
						xfer_valid     <= 1'b1;
						xfer_chan      <= cur_q;
						xfer_c2h       <= cur_c2h;
						xfer_buf       <= desc_rsp_buf;
						xfer_len       <= desc_rsp_len;
						xfer_sop       <= desc_rsp_sop;  // see RULE11
						xfer_eop       <= desc_rsp_eop;
						xfer_user      <= cur_c2h ? 32'h0000_0000 : desc_rsp_user;  // see RULE13
						state_q        <= S_MOVE;
					end
				end
				S_MOVE: begin
					if (xfer_done) begin
						xfer_valid <= 1'b0;
						wb_valid   <= 1'b1;
						wb_addr    <= cur_ptr;
						wb_status  <= 32'h0000_0000;
						wb_status[`DMARM_WB_DONE]  <= 1'b1;  // see RULE6
						wb_status[`DMARM_WB_ERR]   <= xfer_err | d_err_q;  // see RULE17
						wb_status[`DMARM_WB_SHORT] <= xfer_short & ~cur_c2h;  // see RULE18
						wb_status[`DMARM_WB_SOP]   <= wb_sop;  // see RULE15
						wb_status[`DMARM_WB_EOP]   <= wb_eop;
						wb_status[19:0]            <= xfer_count;  // see RULE16
						wb_ustat   <= cur_c2h ? xfer_ustat : 32'h0000_0000;
						state_q    <= S_WB;
					end
				end
				S_WB: begin
					// tell software per packet, not per prepared chain, see RULE8
					pkt_done_pulse[cur_q] <= wb_status[`DMARM_WB_EOP] | d_irq_q;
					rr_q    <= cur_q;
					state_q <= S_IDLE;  // see RULE14
				end
				default: begin
					state_q <= S_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// software-visible pointers and control
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (j = 0; j < `DMARM_NCHAN; j = j + 1) begin
				ctrl_q[j]  <= 32'h0000_0000;
				base_q[j]  <= 32'h0000_0000;
				fetch_q[j] <= 32'h0000_0000;
				tail_q[j]  <= 32'h0000_0000;
				done_q[j]  <= 32'h0000_0000;
				coal_q[j]  <= 16'h0000;
			end
			coal_pulse <= 4'h0;
		end else begin
			coal_pulse <= 4'h0;
			if (wr_ok) begin
				case (a_reg)
					`DMARM_REG_CTRL:  ctrl_q[a_ch]  <= pwdata;
					`DMARM_REG_BASE:  base_q[a_ch]  <= pwdata;
					`DMARM_REG_FETCH: fetch_q[a_ch] <= pwdata;
					`DMARM_REG_TAIL:  tail_q[a_ch]  <= pwdata;  // see RULE5
					`DMARM_REG_DONE:  done_q[a_ch]  <= pwdata;
					default: begin
					end
				endcase
			end
			// engine updates win over a software write in the same cycle
			if (finish) begin
				fetch_q[cur_q] <= next_ptr;  // see RULE4 see RULE22
				done_q[cur_q]  <= cur_ptr;  // see RULE3
				// see RULE21
				if (coal_n != 16'h0000 && coal_q[cur_q] + 16'h0001 >= coal_n) begin
					coal_q[cur_q]     <= 16'h0000;
					coal_pulse[cur_q] <= 1'b1;
				end else begin
					coal_q[cur_q] <= coal_q[cur_q] + 16'h0001;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// one-second enable and statistics
	// slower rates are enables from this counter, never a second clock
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sec_q      <= 32'h0000_0000;
			sec_tick_q <= 1'b0;
		end else if (sec_q >= SEC_CYCLES - 1) begin
			sec_q      <= 32'h0000_0000;
			sec_tick_q <= 1'b1;
		end else begin
			sec_q      <= sec_q + 32'h0000_0001;
			sec_tick_q <= 1'b0;
		end
	end

	genvar g;
	generate
		for (g = 0; g < `DMARM_NCHAN; g = g + 1) begin : g_chan
			wire busy_c  = (state_q != S_IDLE) & (cur_q == g);
			// waiting: enabled with nothing submitted, see RULE23
			wire wait_c  = ctrl_q[g][`DMARM_CTRL_EN] & (fetch_q[g] == tail_q[g]);
			wire clr_c   = wr_ok & (a_ch == g) & (a_reg == `DMARM_REG_ERRS);
			wire hit_err = finish & (cur_q == g) & wb_status[`DMARM_WB_ERR];
			wire hit_sh  = finish & (cur_q == g) & wb_status[`DMARM_WB_SHORT];
			dmarm_ns_meter u_act (
				.pclk      (pclk),
				.presetn   (presetn),
				.sec_tick  (sec_tick_q),
				.busy      (busy_c),
				.last_ns_q (act_ns[g])
			);  // see RULE19
			dmarm_ns_meter u_wait (
				.pclk      (pclk),
				.presetn   (presetn),
				.sec_tick  (sec_tick_q),
				.busy      (wait_c),
				.last_ns_q (wait_ns[g])
			);  // see RULE20
			dmarm_err_count u_err (
				.pclk    (pclk),
				.presetn (presetn),
				.hit     (hit_err),
				.clr     (clr_c),
				.count_q (err_cnt[g])
			);
			dmarm_err_count u_short (
				.pclk    (pclk),
				.presetn (presetn),
				.hit     (hit_sh),
				.clr     (clr_c),
				.count_q (short_cnt[g])
			);
		end
	endgenerate
endmodule // dmarm_ring_mgr

// ===== dmarm_defs.vh
// What this block does
// RULE1 - driver builds one 8,192-descriptor ring per channel before enabling it
// RULE2 - four channels, four rings, each with its own pointer set
// RULE3 - completed pointer holds address of last finished descriptor
// RULE4 - fetch pointer holds next descriptor, advances on each consumed one
// RULE5 - software tail pointer, written by software, limits what engine may use
// RULE6 - write-back reports completion, packet start and packet end per descriptor
// RULE7 - software and engine work their ring shares independently, producer-consumer
// RULE8 - software is told of each packet as it completes
// RULE9 - transmit init: fetch and tail at ring start, clear completed, enable
// RULE10 - receive init: buffers attached, fetch at start, tail at end, enable
// RULE11 - transmit packet may span several descriptors, gathered into one packet
// RULE12 - software marks start, end and interrupt flags in transmit descriptors
// RULE13 - transmit user control information travels along with the packet data
// RULE14 - transmit keeps consuming while software keeps advancing the tail
// RULE15 - receive write-back carries completion, start, end and user status
// RULE16 - receive write-back carries the actual received byte count
// RULE17 - a descriptor causing a DMA error gets its error field set
// RULE18 - short error flagged on transmit only, when full length not fetched
// RULE19 - active time in ns over the last second, per engine
// RULE20 - time waiting for descriptors in ns, per engine, readable
// RULE21 - notify after every N processed descriptors, N programmable
// RULE22 - fetch pointer wraps to ring start after the last descriptor
// RULE23 - engine stalls and counts wait while fetch equals tail
`ifndef DMARM_DEFS_VH
`define DMARM_DEFS_VH

`define DMARM_NCHAN        4
`define DMARM_RING_DESCS   8192
`define DMARM_DESC_BYTES   32'h0000_0020
`define DMARM_RING_LAST    32'h0003_ffe0

// register map, word indices within a channel (byte offset is four times the index), channel stride 0x20
`define DMARM_REG_CTRL     3'h0
`define DMARM_REG_BASE     3'h1
`define DMARM_REG_FETCH    3'h2
`define DMARM_REG_TAIL     3'h3
`define DMARM_REG_DONE     3'h4
`define DMARM_REG_ACTIVE   3'h5
`define DMARM_REG_WAIT     3'h6
`define DMARM_REG_ERRS     3'h7
`define DMARM_OFF_ID       12'h080
`define DMARM_ID_VALUE     32'h0a5c_0001  // arbitrary value, names no real part

// control fields
`define DMARM_CTRL_EN      0
`define DMARM_CTRL_C2H     1
`define DMARM_CTRL_N_LO    8
`define DMARM_CTRL_N_HI    23

// write-back status fields
`define DMARM_WB_DONE      31
`define DMARM_WB_ERR       30
`define DMARM_WB_SHORT     29
`define DMARM_WB_SOP       28
`define DMARM_WB_EOP       27

// timing
`define DMARM_CLK_NS       5
`define DMARM_SEC_NS       1000000000

`endif

// ===== dmarm_ns_meter.v
`timescale 1ns/1ps
// accumulates ns while busy, snapshots on each one-second tick
module dmarm_ns_meter (
	// clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// measurement
	input  wire        sec_tick,
	input  wire        busy,
	output reg  [31:0] last_ns_q
);
	reg [31:0] acc_q;
	wire [31:0] step = busy ? `DMARM_CLK_NS : 32'h0000_0000;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_q     <= 32'h0000_0000;
			last_ns_q <= 32'h0000_0000;
		end else if (sec_tick) begin
			last_ns_q <= acc_q + step;
			acc_q     <= 32'h0000_0000;
		end else begin
			acc_q <= acc_q + step;
		end
	end
endmodule // dmarm_ns_meter

// ===== dmarm_err_count.v
`timescale 1ns/1ps
// saturating event counter, cleared by software
module dmarm_err_count (
	// clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// events
	input  wire        hit,
	input  wire        clr,
	output reg  [15:0] count_q
);
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q <= 16'h0000;
		end else if (hit) begin
			// an event in the clearing cycle is kept
			count_q <= clr ? 16'h0001 : ((count_q == 16'hffff) ? count_q : count_q + 16'h0001);
		end else if (clr) begin
			count_q <= 16'h0000;
		end
	end
endmodule // dmarm_err_count

// ===== dmarm_ring_mgr_sva.sv
`timescale 1ns/1ps
module dmarm_ring_mgr_sva #(
	parameter SEC_CYCLES = 100
) (
	input wire        pclk,
	input wire        presetn,
	input wire        desc_req_valid,
	input wire [31:0] desc_req_addr,
	input wire        desc_rsp_valid,
	input wire [31:0] desc_rsp_user,
	input wire        xfer_valid,
	input wire        xfer_c2h,
	input wire [31:0] xfer_user,
	input wire        xfer_done,
	input wire [19:0] xfer_count,
	input wire        xfer_err,
	input wire        wb_valid,
	input wire [31:0] wb_addr,
	input wire [31:0] wb_status,
	input wire [3:0]  pkt_done_pulse,
	input wire [3:0]  coal_pulse
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////
	property p_rsp_to_xfer;
		desc_req_valid && desc_rsp_valid |=> xfer_valid && !desc_req_valid;
	endproperty
	a_rsp_to_xfer: assert property (p_rsp_to_xfer) else $error("no move after fetch");
	property p_req_hold;
		desc_req_valid && !desc_rsp_valid |=> desc_req_valid && $stable(desc_req_addr);
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("fetch request dropped");
	property p_done_to_wb;
		xfer_valid && xfer_done |=> wb_valid ##1 !wb_valid;
	endproperty
	a_done_to_wb: assert property (p_done_to_wb) else $error("write-back missing");
	property p_wb_done_bit;
		wb_valid |-> wb_status[31];
	endproperty
	a_wb_done_bit: assert property (p_wb_done_bit) else $error("done bit clear");
	property p_wb_addr;
		xfer_valid && xfer_done |=> wb_addr == $past(desc_req_addr);
	endproperty
	a_wb_addr: assert property (p_wb_addr) else $error("write-back address wrong");
	property p_count;
		xfer_valid && xfer_done |=> wb_status[19:0] == $past(xfer_count);
	endproperty
	a_count: assert property (p_count) else $error("byte count wrong");
	property p_err;
		xfer_valid && xfer_done && xfer_err |=> wb_status[30];
	endproperty
	a_err: assert property (p_err) else $error("error bit clear");
	property p_short_rx;
		xfer_valid && xfer_done && xfer_c2h |=> !wb_status[29];
	endproperty
	a_short_rx: assert property (p_short_rx) else $error("short set on receive");
	property p_pkt;
		wb_valid && wb_status[27] |=> pkt_done_pulse != 4'h0;
	endproperty
	a_pkt: assert property (p_pkt) else $error("packet end not notified");
	property p_user;
		desc_req_valid && desc_rsp_valid |=> xfer_c2h || xfer_user == $past(desc_rsp_user);
	endproperty
	a_user: assert property (p_user) else $error("user control lost");
	c_err: cover property (wb_valid && wb_status[30]);
	c_rx: cover property (xfer_done && xfer_c2h);
	c_coal: cover property (coal_pulse != 4'h0);
endmodule // dmarm_ring_mgr_sva

bind dmarm_ring_mgr dmarm_ring_mgr_sva #(.SEC_CYCLES(SEC_CYCLES)) u_dmarm_ring_mgr_sva (.*);

// ===== dmarm_host_model.sv
`timescale 1ns/1ps
// descriptor memory and data mover; slower for some descriptor addresses
module dmarm_host_model (
	// clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// descriptor fetch
	input  wire        desc_req_valid,
	input  wire [31:0] desc_req_addr,
	output reg         desc_rsp_valid,
	output reg  [31:0] desc_rsp_buf,
	output reg  [19:0] desc_rsp_len,
	output reg         desc_rsp_sop,
	output reg         desc_rsp_eop,
	output reg         desc_rsp_irq,
	output reg  [31:0] desc_rsp_user,
	output reg         desc_rsp_err,
	// data movement
	input  wire        xfer_valid,
	input  wire        xfer_c2h,
	input  wire [31:0] xfer_buf,
	input  wire [19:0] xfer_len,
	output reg         xfer_done,
	output reg  [19:0] xfer_count,
	output reg         xfer_err,
	output reg         xfer_short,
	output reg         xfer_rx_sop,
	output reg         xfer_rx_eop,
	output reg  [31:0] xfer_ustat
);
	reg [2:0] wait_q;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{desc_rsp_valid, desc_rsp_buf, desc_rsp_len, desc_rsp_sop, desc_rsp_eop} <= 0;
			{desc_rsp_irq, desc_rsp_user, desc_rsp_err, xfer_done, xfer_count} <= 0;
			{xfer_err, xfer_short, xfer_rx_sop, xfer_rx_eop, xfer_ustat, wait_q} <= 0;
		end else begin
			desc_rsp_valid <= 1'b0;
			xfer_done <= 1'b0;
			// idle buffer, length, count and user status fields keep changing so a stale value is never trusted
			{desc_rsp_buf, desc_rsp_len} <= ~{desc_rsp_buf, desc_rsp_len};
			{xfer_count, xfer_ustat} <= ~{xfer_count, xfer_ustat};
			if ((desc_req_valid || xfer_valid) && !desc_rsp_valid && !xfer_done) begin
				wait_q <= wait_q + 3'h1;
				if (wait_q >= {1'b0, desc_req_addr[6:5]}) begin
					wait_q <= 3'h0;
					if (xfer_valid) begin
						xfer_done <= 1'b1;
						xfer_count <= xfer_c2h ? xfer_len - 20'h4 : xfer_len;
						xfer_err <= xfer_buf[11:0] == 12'h040;
						xfer_short <= xfer_c2h || xfer_buf[11:0] == 12'h020; // rx raises it too
						{xfer_rx_sop, xfer_rx_eop} <= 2'h3;
						xfer_ustat <= ~xfer_buf;
					end else begin
						desc_rsp_valid <= 1'b1;
						desc_rsp_buf <= desc_req_addr + 32'h0001_0000;
						desc_rsp_len <= 20'h00040;
						// two descriptors form one packet
						desc_rsp_sop <= !desc_req_addr[5];
						desc_rsp_eop <= desc_req_addr[5];
						desc_rsp_irq <= 1'b0;
						desc_rsp_user <= desc_req_addr;
						desc_rsp_err <= 1'b0;
					end
				end
			end
		end
	end
endmodule // dmarm_host_model

// ===== dmarm_ring_mgr_tb.sv
`timescale 1ns/1ps
`include "dmarm_defs.vh"
`define CHK(nm, ex, gt) begin num_checks = num_checks + 1; if ((gt) !== (ex)) begin \
	mismatches = mismatches + 1; $display("FAIL %s exp %h got %h", nm, ex, gt); end end
module dmarm_ring_mgr_tb;
	reg         pclk, presetn, psel, penable, pwrite, err;
	reg  [11:0] paddr;
	reg  [31:0] pwdata, rd;
	reg  [31:0] wb_a, wb_s, wb_u;
	wire        pready, pslverr, desc_req_valid, desc_rsp_valid, desc_rsp_sop, desc_rsp_eop;
	wire        desc_rsp_irq, desc_rsp_err, xfer_valid, xfer_c2h, xfer_sop, xfer_eop, xfer_done;
	wire        xfer_err, xfer_short, xfer_rx_sop, xfer_rx_eop, wb_valid;
	wire [1:0]  desc_req_chan, xfer_chan;
	wire [19:0] desc_rsp_len, xfer_len, xfer_count;
	wire [31:0] prdata, desc_req_addr, desc_rsp_buf, desc_rsp_user, xfer_buf, xfer_user;
	wire [31:0] xfer_ustat, wb_addr, wb_status, wb_ustat;
	wire [3:0]  pkt_done_pulse, coal_pulse;
	integer     mismatches, num_checks, wb_cnt, pkt_cnt, coal_cnt;
	dmarm_ring_mgr #(.SEC_CYCLES(100)) u_dmarm_ring_mgr (.*);
	dmarm_host_model u_dmarm_host_model (.*);
	always #2.5 pclk = ~pclk;
	always @(posedge pclk) begin
		wb_cnt = wb_cnt + (wb_valid === 1'b1);
		pkt_cnt = pkt_cnt + ((|pkt_done_pulse) === 1'b1);
		coal_cnt = coal_cnt + ((|coal_pulse) === 1'b1);
		if (wb_valid === 1'b1) begin
			wb_a = wb_addr;
			wb_s = wb_status;
			wb_u = wb_ustat;
		end
	end
	////////////////////////////////////////////////////////////////
	task report_and_stop;
		begin
			if (mismatches == 0 && num_checks > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask
	task apb(input w, input [11:0] a, input [31:0] d);
		begin
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			@(posedge pclk);
			while (pready !== 1'b1)
				@(posedge pclk);
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge pclk);
		end
	endtask
	task rd_chk(input [11:0] a, input [31:0] ex);
		begin
			apb(1'b0, a, 32'h0);
			`CHK("reg", ex, rd)
		end
	endtask
	// polls a fetch pointer until it reaches ex, bounded
	task wait_ptr(input [11:0] a, input [31:0] ex);
		integer i;
		begin
			i = 0;
			apb(1'b0, a, 32'h0);
			while (rd !== ex && i < 80) begin
				apb(1'b0, a, 32'h0);
				i = i + 1;
			end
			`CHK("fetch", ex, rd)
		end
	endtask
	task setup(input [11:0] c, input [31:0] b, input [31:0] f, input [31:0] t, input [31:0] k);
		begin
			apb(1'b1, c + 12'h004, b);
			apb(1'b1, c + 12'h008, f);
			apb(1'b1, c + 12'h00c, t);
			apb(1'b1, c + 12'h010, 32'h0);
			apb(1'b1, c, k);
		end
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge pclk);
		mismatches = mismatches + 1;
		report_and_stop;
	end
	initial begin
		{pclk, presetn, psel, penable, pwrite, paddr, pwdata} = 0;
		{mismatches, num_checks, wb_cnt, pkt_cnt, coal_cnt} = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, 12'h0fc, 32'h0);
		`CHK("slverr", 1'b1, err)
		rd_chk(12'h080, `DMARM_ID_VALUE);
		setup(12'h000, 32'h1000, 32'h1000, 32'h1000, 32'h0000_0201);
		apb(1'b1, 12'h00c, 32'h1060);
		wait_ptr(12'h008, 32'h1060);
		rd_chk(12'h010, 32'h1040);
		`CHK("wb", 3, wb_cnt)
		`CHK("pkt", 1, pkt_cnt)
		`CHK("coal", 1, coal_cnt)
		rd_chk(12'h01c, 32'h0001_0001);
		apb(1'b1, 12'h01c, 32'h0);
		rd_chk(12'h01c, 32'h0);
		apb(1'b1, 12'h00c, 32'h1080);
		wait_ptr(12'h008, 32'h1080);
		`CHK("wb_addr", 32'h0000_1060, wb_a)
		`CHK("wb_status", 32'h8800_0040, wb_s)
		`CHK("coal2", 2, coal_cnt)
		setup(12'h020, 32'h20000, 32'h20000, 32'h5ffe0, 32'h3);
		// disabling at once stops the engine after the descriptor already in flight
		apb(1'b1, 12'h020, 32'h2);
		wait_ptr(12'h028, 32'h20020);
		rd_chk(12'h030, 32'h20000);
		`CHK("rx_addr", 32'h0002_0000, wb_a)
		`CHK("rx_status", 32'h9800_003c, wb_s)
		`CHK("rx_ustat", 32'hfffc_ffff, wb_u)
		// resume at the ring's last descriptor to see the wrap
		apb(1'b1, 12'h028, 32'h5ffe0);
		apb(1'b1, 12'h02c, 32'h20000);
		apb(1'b1, 12'h020, 32'h3);
		wait_ptr(12'h028, 32'h20000);
		rd_chk(12'h030, 32'h5ffe0);
		rd_chk(12'h008, 32'h1080);
		rd_chk(12'h03c, 32'h0);
		`CHK("coal3", 2, coal_cnt)
		repeat (250) @(posedge pclk);
		rd_chk(12'h018, 32'h0000_01f4);
		rd_chk(12'h014, 32'h0000_0000);
		report_and_stop;
	end
endmodule // dmarm_ring_mgr_tb
